/* bench/tb.sv */
// self-checking bench for the endpoint control block
// assumes the host model drives the token side
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %0t got %0h want %0h", $time, g, e); end end

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import usb_ep_pkg::*;
	logic ref_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tx_byte_data, v;
	logic bus_activity_pin = 1'b0, suspended = 1'b0, token_valid, rx_packet_ok, host_ack;
	logic tx_byte_ready, resp_valid, resp_data1, tx_byte_valid, tx_byte_last, resume_k_drive;
	logic [3:0] token_endpoint;
	logic [3:0] cnt[3];
	logic [7:0] mem[16];
	token_e token_kind;
	resp_e resp_kind;
	int num_errors = 0, compares = 0;
	always #20 ref_clk = ~ref_clk;
	usb_endpoint_tx_control dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.token_valid(token_valid), .token_kind(token_kind), .token_endpoint(token_endpoint),
		.rx_packet_ok(rx_packet_ok), .host_ack(host_ack), .bus_activity_pin(bus_activity_pin),
		.suspended(suspended), .resp_valid(resp_valid), .resp_kind(resp_kind),
		.resp_data1(resp_data1), .tx_byte_valid(tx_byte_valid), .tx_byte_data(tx_byte_data),
		.tx_byte_last(tx_byte_last), .tx_byte_ready(tx_byte_ready),
		.resume_k_drive(resume_k_drive));
	usb_host_model h (.ref_clk(ref_clk), .token_valid(token_valid), .token_kind(token_kind),
		.token_endpoint(token_endpoint), .rx_packet_ok(rx_packet_ok), .host_ack(host_ack),
		.tx_byte_ready(tx_byte_ready), .resp_valid(resp_valid), .resp_kind(resp_kind),
		.resp_data1(resp_data1), .tx_byte_valid(tx_byte_valid), .tx_byte_data(tx_byte_data),
		.tx_byte_last(tx_byte_last));
	function automatic logic [7:0] ctrl(input logic t, input logic s, input logic [3:0] n);
		return {t, s, 2'b10, n};
	endfunction : ctrl
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(posedge ref_clk);
		`CHK(reg_rdata, e)
	endtask : rd
	task automatic xchk(input token_e k, input logic [3:0] ep, input resp_e e);
		h.xfer(k, ep, 0, 1'b0);
		`CHK({h.seen, h.kind}, {1'b1, e})
	endtask : xchk
	task automatic ep_in(input logic [7:0] ca, input logic [7:0] da, input logic [3:0] ep,
			input logic [7:0] c);
		wr(ca, c);
		for (int i = 0; i < c[3:0]; i++) begin
			mem[i] = $urandom;
			wr(da, mem[i]);
		end
		h.xfer(TOKEN_IN, ep, 2, 1'b1);
		`CHK({h.seen, h.kind}, {1'b1, RESP_DATA})
		`CHK(h.d1, c[7])
		`CHK(h.got.size(), int'(c[3:0]))
		foreach (h.got[i]) `CHK(h.got[i], mem[i])
	endtask : ep_in
	initial begin
		repeat (60000) @(posedge ref_clk);
		num_errors++;
		summarize();
	end
	initial begin
		void'($urandom(61));
		cnt = '{4'h0, 4'hf, 4'h1};
		cnt[2] = $urandom_range(14, 1);
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (cnt[i]) rd(ADDR_EP0_CTRL + 8'(i), 8'h00);
		rd(ADDR_FLAGS, 8'h00);
		repeat (4) begin
			v = $urandom;
			wr(ADDR_EP0_CTRL, v);
			rd(ADDR_EP0_CTRL, v);
			wr(ADDR_EP12_CTRL, v);
			rd(ADDR_EP12_CTRL, v);
			`CHK(resume_k_drive, v[4])
			wr(ADDR_EP_CTRL, v);
			rd(ADDR_EP_CTRL, v & EP_CTRL_MASK);
		end
		wr(ADDR_EP12_CTRL, 8'h00);
		wr(ADDR_EP_CTRL, 8'h00);
		$display("registers done");
		foreach (cnt[k]) begin
			ep_in(ADDR_EP0_CTRL, ADDR_EP0_DATA, 4'h0, ctrl(k[0], 1'b0, cnt[k]));
			rd(ADDR_FLAGS, 8'h10);
			xchk(TOKEN_IN, 4'h0, RESP_NAK);
			wr(ADDR_FLAGS, 8'h10);
		end
		wr(ADDR_EP0_CTRL, 8'h00);
		xchk(TOKEN_IN, 4'h0, RESP_NAK);
		xchk(TOKEN_OUT, 4'h0, RESP_NAK);
		wr(ADDR_EP0_CTRL, 8'h70);
		xchk(TOKEN_IN, 4'h0, RESP_STALL);
		xchk(TOKEN_OUT, 4'h0, RESP_STALL);
		xchk(TOKEN_SETUP, 4'h0, RESP_ACK);
		rd(ADDR_EP0_CTRL, 8'h30);
		rd(ADDR_FLAGS, 8'h08);
		xchk(TOKEN_OUT, 4'h0, RESP_NAK);
		wr(ADDR_FLAGS, 8'h08);
		xchk(TOKEN_OUT, 4'h0, RESP_ACK);
		rd(ADDR_FLAGS, 8'h08);
		wr(ADDR_FLAGS, 8'h08);
		// status stage out: acked but leaves the receive flag alone
		wr(ADDR_EP_CTRL, 8'h10);
		xchk(TOKEN_OUT, 4'h0, RESP_ACK);
		rd(ADDR_FLAGS, 8'h00);
		$display("endpoint 0 done");
		wr(ADDR_EP_CTRL, 8'h0c);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_EP12_CTRL, ctrl(1'b0, s[0], 4'h0));
			xchk(TOKEN_IN, s[0] ? 4'h1 : 4'h2, RESP_NAK);
			ep_in(ADDR_EP12_CTRL, ADDR_SHARED_DATA, s[0] ? 4'h2 : 4'h1, ctrl(~s[0], s[0], cnt[2]));
			rd(ADDR_FLAGS, 8'h04);
			xchk(TOKEN_IN, s[0] ? 4'h2 : 4'h1, RESP_NAK);
			wr(ADDR_FLAGS, 8'h04);
		end
		wr(ADDR_EP_CTRL, 8'h0a);
		xchk(TOKEN_IN, 4'h2, RESP_STALL);
		$display("shared path done");
		// wake-up hold kept short here; the block does not time it
		wr(ADDR_EP12_CTRL, 8'h10);
		suspended <= 1'b1;
		bus_activity_pin <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rd(ADDR_FLAGS, 8'h00);
		bus_activity_pin <= 1'b0;
		repeat (6) @(posedge ref_clk);
		wr(ADDR_EP12_CTRL, 8'h00);
		rd(ADDR_FLAGS, 8'h00);
		bus_activity_pin <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rd(ADDR_FLAGS, 8'h01);
		$display("wake-up done");
		summarize();
	end
endmodule : tb

`default_nettype wire

/* bench/usb_ep_monitor.sv */
// port assertions for the endpoint control block
// assumes one ref_clk domain, bound to usb_endpoint_tx_control
`default_nettype none

module usb_ep_monitor
	import usb_ep_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic token_valid,
	input wire usb_ep_pkg::token_e token_kind,
	input wire logic [3:0] token_endpoint,
	input wire logic resp_valid,
	input wire usb_ep_pkg::resp_e resp_kind,
	input wire logic resp_data1,
	input wire logic tx_byte_valid,
	input wire logic [7:0] tx_byte_data,
	input wire logic tx_byte_last,
	input wire logic tx_byte_ready,
	input wire logic resume_k_drive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ep0_reg;
	logic [7:0] sh_reg;
	logic [4:0] ctl_reg;
	logic tok_in;
	assign tok_in = token_valid && token_kind == TOKEN_IN;
	// mirror of the endpoint 0 control register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ep0_reg <= 8'h00;
		end else begin
			if (reg_write && reg_addr == ADDR_EP0_CTRL) begin
				ep0_reg <= reg_wdata;
			end
			if (token_valid && token_kind == TOKEN_SETUP && token_endpoint == 4'h0) begin
				ep0_reg[6] <= 1'b0;
			end
		end
	end
	// mirrors of the shared and endpoint control registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sh_reg <= 8'h00;
			ctl_reg <= 5'h00;
		end else begin
			if (reg_write && reg_addr == ADDR_EP12_CTRL) sh_reg <= reg_wdata;
			if (reg_write && reg_addr == ADDR_EP_CTRL) ctl_reg <= reg_wdata[4:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_data;
		resp_valid && resp_kind == RESP_DATA;
	endsequence
	sequence s_ep0_in;
		tok_in && token_endpoint == 4'h0 && !ep0_reg[6];
	endsequence
	a_wake_level: assert property (resume_k_drive == sh_reg[4])
		else $error("wake drive wrong");
	a_ep0_stall: assert property ((tok_in || token_valid && token_kind == TOKEN_OUT)
		&& token_endpoint == 4'h0 && ep0_reg[6] |=> resp_valid && resp_kind == RESP_STALL)
		else $error("no stall");
	a_ep0_tx_nak: assert property (s_ep0_in ##0 !ep0_reg[5]
		|=> resp_valid && resp_kind == RESP_NAK) else $error("ep0 in not refused");
	a_ep0_rx_nak: assert property (token_valid && token_kind == TOKEN_OUT
		&& token_endpoint == 4'h0 && ep0_reg[6:4] == 3'b000 && !ctl_reg[4]
		|=> resp_valid && resp_kind == RESP_NAK) else $error("ep0 out not refused");
	a_ep0_pid: assert property (s_ep0_in ##1 s_data
		|-> resp_data1 == $past(ep0_reg[7])) else $error("ep0 pid wrong");
	a_sel_nak: assert property (tok_in && token_endpoint == 4'h2 && ctl_reg[3]
		&& !ctl_reg[1] && sh_reg[6:5] == 2'b01 |=> resp_valid && resp_kind == RESP_NAK)
		else $error("ep2 not refused");
	a_shared_pid: assert property (tok_in && token_endpoint inside {4'h1, 4'h2}
		##1 s_data |-> resp_data1 == $past(sh_reg[7])) else $error("shared pid wrong");
	a_byte_hold: assert property (tx_byte_valid && !tx_byte_ready && !token_valid
		|=> tx_byte_valid && $stable(tx_byte_data) && $stable(tx_byte_last))
		else $error("byte dropped");
endmodule : usb_ep_monitor

bind usb_endpoint_tx_control usb_ep_monitor mon (.ref_clk(ref_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.token_valid(token_valid), .token_kind(token_kind), .token_endpoint(token_endpoint),
	.resp_valid(resp_valid), .resp_kind(resp_kind), .resp_data1(resp_data1),
	.tx_byte_valid(tx_byte_valid), .tx_byte_data(tx_byte_data), .tx_byte_last(tx_byte_last),
	.tx_byte_ready(tx_byte_ready), .resume_k_drive(resume_k_drive));

`default_nettype wire

/* bench/usb_host_model.sv */
// host side: tokens, packet-ok and ack pulses, byte sink with stalls
// assumes tasks are entered right after a rising ref_clk edge
`default_nettype none

module usb_host_model
	import usb_ep_pkg::*;
(
	input wire logic ref_clk,
	output logic token_valid,
	output usb_ep_pkg::token_e token_kind,
	output logic [3:0] token_endpoint,
	output logic rx_packet_ok,
	output logic host_ack,
	output logic tx_byte_ready,
	input wire logic resp_valid,
	input wire usb_ep_pkg::resp_e resp_kind,
	input wire logic resp_data1,
	input wire logic tx_byte_valid,
	input wire logic [7:0] tx_byte_data,
	input wire logic tx_byte_last
);
	timeunit 1ns;
	timeprecision 1ns;
	logic seen, d1, fin;
	resp_e kind;
	logic [7:0] got[$];
	initial begin
		token_valid = 1'b0;
		token_kind = TOKEN_OTHER;
		token_endpoint = 4'h0;
		rx_packet_ok = 1'b0;
		host_ack = 1'b0;
		tx_byte_ready = 1'b0;
	end
	task automatic xfer(input token_e k, input logic [3:0] ep, input int lag, input logic ack);
		got.delete();
		fin = 1'b0;
		token_valid <= 1'b1;
		token_kind <= k;
		token_endpoint <= ep;
		@(posedge ref_clk);
		token_valid <= 1'b0;
		token_endpoint <= ~ep;
		@(posedge ref_clk);
		seen = resp_valid;
		kind = resp_kind;
		d1 = resp_data1;
		if (!seen && k != TOKEN_IN) begin
			rx_packet_ok <= 1'b1;
			@(posedge ref_clk);
			rx_packet_ok <= 1'b0;
			@(posedge ref_clk);
			seen = resp_valid;
			kind = resp_kind;
		end
		for (int t = 0; t < 120 && seen && kind == RESP_DATA && !fin; t++) begin
			tx_byte_ready <= ($urandom_range(lag, 0) == 0);
			@(posedge ref_clk);
			if (tx_byte_valid && tx_byte_ready) begin
				got.push_back(tx_byte_data);
				fin = tx_byte_last;
			end
		end
		tx_byte_ready <= 1'b0;
		host_ack <= ack && seen && kind == RESP_DATA;
		@(posedge ref_clk);
		host_ack <= 1'b0;
		@(posedge ref_clk);
	endtask : xfer
endmodule : usb_host_model

`default_nettype wire

/* verilog/tx_buf_if.sv */
// write and read port of the transmit data storage
// assumes both sides sit on ref_clk
`default_nettype none

interface tx_buf_if;
	logic we;
	logic wsel;
	logic [3:0] waddr;
	logic [7:0] wdata;
	logic rsel;
	logic [3:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, wsel, waddr, wdata, rsel, raddr, input rdata);
	modport mem (input we, wsel, waddr, wdata, rsel, raddr, output rdata);
endinterface : tx_buf_if

`default_nettype wire

/* verilog/usb_endpoint_tx_control.sv */
// endpoint handshake and transmit control for a low-speed usb function
// assumes token and packet strobes come from a serial engine on ref_clk
`default_nettype none

module usb_endpoint_tx_control
	import usb_ep_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic token_valid,
	input wire usb_ep_pkg::token_e token_kind,
	input wire logic [3:0] token_endpoint,
	input wire logic rx_packet_ok,
	input wire logic host_ack,
	input wire logic bus_activity_pin,
	input wire logic suspended,
	output logic resp_valid,
	output usb_ep_pkg::resp_e resp_kind,
	output logic resp_data1,
	output logic tx_byte_valid,
	output logic [7:0] tx_byte_data,
	output logic tx_byte_last,
	input wire logic tx_byte_ready,
	output logic resume_k_drive
);
	import usb_ep_pkg::*;

	typedef enum {ST_IDLE, ST_FETCH, ST_SHOW, ST_WAIT_ACK, ST_WAIT_DATA} state_e;

	tx_buf_if buf_bus ();

	state_e state_reg;
	logic [7:0] ep0_ctrl_reg;
	logic [7:0] ep12_ctrl_reg;
	logic [4:0] ep_ctrl_reg;
	logic tx0_done_reg, rx0_done_reg, tx1_done_reg, resume_flag_reg;
	logic [3:0] ep0_wptr_reg, shared_wptr_reg;
	logic [3:0] byte_ptr_reg, byte_count_reg;
	logic cur_shared_reg, status_only_reg;
	logic act1_reg, act2_reg, act3_reg, activity_reg;
	logic [7:0] rdata_reg;
	logic resp_valid_reg, resp_data1_reg, tx_valid_reg, tx_last_reg;
	resp_e resp_kind_reg;

	logic dec_respond, dec_send, dec_recv, dec_shared, dec_data1, dec_status_only;
	resp_e dec_kind;
	logic [3:0] dec_count;
	logic ep12_en, ep12_stall, setup_seen;
	logic tx_ack_event, rx_ok_event;

	usb_tx_buffer u_buffer (
		.ref_clk(ref_clk),
		.reset(reset),
		.buf_port(buf_bus.mem)
	);

	assign buf_bus.we = reg_write && (reg_addr == ADDR_EP0_DATA || reg_addr == ADDR_SHARED_DATA);
	assign buf_bus.wsel = (reg_addr == ADDR_SHARED_DATA);
	assign buf_bus.waddr = (reg_addr == ADDR_SHARED_DATA) ? shared_wptr_reg : ep0_wptr_reg;
	assign buf_bus.wdata = reg_wdata;
	assign buf_bus.rsel = cur_shared_reg;
	assign buf_bus.raddr = byte_ptr_reg;

	assign setup_seen = token_valid && token_kind == TOKEN_SETUP && token_endpoint == 4'h0;
	assign ep12_en = (token_endpoint == 4'h1) ? ep_ctrl_reg[EP1_EN_BIT] : ep_ctrl_reg[EP2_EN_BIT];
	assign ep12_stall = (token_endpoint == 4'h1) ? ep_ctrl_reg[EP1_STALL_BIT]
		: ep_ctrl_reg[EP2_STALL_BIT];

	// token decision
	always_comb begin
		dec_respond = 1'b0;
		dec_kind = RESP_NAK;
		dec_send = 1'b0;
		dec_recv = 1'b0;
		dec_shared = 1'b0;
		dec_status_only = 1'b0;
		dec_count = ep0_ctrl_reg[3:0]; // see [RL8]
		dec_data1 = ep0_ctrl_reg[EP0_TOGGLE_BIT]; // see [RL1]
		if (token_valid && token_endpoint == 4'h0) begin
			if (token_kind == TOKEN_SETUP) begin
				dec_recv = 1'b1;
			end else if (ep0_ctrl_reg[EP0_STALL_BIT] && token_kind != TOKEN_OTHER) begin
				dec_respond = 1'b1; // see [RL2]
				dec_kind = RESP_STALL;
			end else if (token_kind == TOKEN_IN) begin
				if (path_open(ep0_ctrl_reg[EP0_TXEN_BIT], tx0_done_reg)) begin
					dec_send = 1'b1;
				end else begin
					dec_respond = 1'b1; // see [RL4]
				end
			end else if (token_kind == TOKEN_OUT) begin
				if (ep_ctrl_reg[AUTO_OUT_BIT]) begin
					dec_recv = 1'b1;
					dec_status_only = 1'b1;
				end else if (path_open(ep0_ctrl_reg[EP0_RXEN_BIT], rx0_done_reg)) begin
					dec_recv = 1'b1;
				end else begin
					dec_respond = 1'b1; // see [RL5]
				end
			end
		end else if (token_valid && token_kind == TOKEN_IN && ep12_en
			&& (token_endpoint == 4'h1 || token_endpoint == 4'h2)) begin
			dec_count = ep12_ctrl_reg[3:0]; // see [RL8]
			dec_data1 = ep12_ctrl_reg[SH_TOGGLE_BIT]; // see [RL9]
			dec_shared = 1'b1;
			if (ep12_stall) begin
				dec_respond = 1'b1; // see [RL19]
				dec_kind = RESP_STALL;
			end else if (!path_open(ep12_ctrl_reg[SH_TXEN_BIT], tx1_done_reg)) begin
				dec_respond = 1'b1; // see [RL12]
			end else if (ep12_ctrl_reg[SH_SELECT_BIT] != (token_endpoint == 4'h2)) begin
				dec_respond = 1'b1; // see [RL10] see [RL11]
			end else begin
				dec_send = 1'b1;
			end
		end
	end

	// transaction sequencer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			resp_valid_reg <= 1'b0;
			resp_kind_reg <= RESP_NAK;
			resp_data1_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_last_reg <= 1'b0;
			byte_ptr_reg <= 4'h0;
			byte_count_reg <= 4'h0;
			cur_shared_reg <= 1'b0;
			status_only_reg <= 1'b0;
		end else begin
			resp_valid_reg <= 1'b0;
			if (token_valid) begin
				tx_valid_reg <= 1'b0;
				tx_last_reg <= 1'b0;
				byte_ptr_reg <= 4'h0;
				byte_count_reg <= dec_count;
				cur_shared_reg <= dec_shared;
				status_only_reg <= dec_status_only;
				resp_valid_reg <= dec_respond | dec_send;
				resp_kind_reg <= dec_send ? RESP_DATA : dec_kind;
				resp_data1_reg <= dec_data1;
				if (dec_send) begin
					state_reg <= (dec_count == 4'h0) ? ST_WAIT_ACK : ST_FETCH; // see [RL20]
				end else if (dec_recv) begin
					state_reg <= ST_WAIT_DATA;
				end else begin
					state_reg <= ST_IDLE;
				end
			end else begin
				case (state_reg)
					ST_FETCH: begin
						tx_valid_reg <= 1'b1;
						tx_last_reg <= (byte_ptr_reg == byte_count_reg - 4'h1); // see [RL20]
						state_reg <= ST_SHOW;
					end
					ST_SHOW: begin
						if (tx_byte_ready) begin
							tx_valid_reg <= 1'b0;
							tx_last_reg <= 1'b0;
							if (tx_last_reg) begin
								state_reg <= ST_WAIT_ACK;
							end else begin
								byte_ptr_reg <= byte_ptr_reg + 4'h1;
								state_reg <= ST_FETCH;
							end
						end
					end
					ST_WAIT_ACK: begin
						if (host_ack) begin
							state_reg <= ST_IDLE;
						end
					end
					ST_WAIT_DATA: begin
						if (rx_packet_ok) begin
							resp_valid_reg <= 1'b1;
							resp_kind_reg <= RESP_ACK;
							state_reg <= ST_IDLE;
						end
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end

	assign tx_ack_event = !token_valid && state_reg == ST_WAIT_ACK && host_ack;
	assign rx_ok_event = !token_valid && state_reg == ST_WAIT_DATA && rx_packet_ok
		&& !status_only_reg;

	// control registers, software owned except the endpoint 0 stall bit, which SETUP clears
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ep0_ctrl_reg <= CTRL_RESET;
			ep12_ctrl_reg <= CTRL_RESET;
			ep_ctrl_reg <= EP_CTRL_RESET; // see [RL19]
		end else begin
			if (reg_write && reg_addr == ADDR_EP0_CTRL) begin
				ep0_ctrl_reg <= reg_wdata;
			end
			if (setup_seen) begin
				ep0_ctrl_reg[EP0_STALL_BIT] <= 1'b0; // see [RL3]
			end
			if (reg_write && reg_addr == ADDR_EP12_CTRL) begin
				ep12_ctrl_reg <= reg_wdata;
			end
			if (reg_write && reg_addr == ADDR_EP_CTRL) begin
				ep_ctrl_reg <= reg_wdata[4:0];
			end
		end
	end

	// storage write pointers, rewound by a control write
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ep0_wptr_reg <= 4'h0;
			shared_wptr_reg <= 4'h0;
		end else begin
			if (reg_write && reg_addr == ADDR_EP0_CTRL) begin
				ep0_wptr_reg <= 4'h0;
			end else if (reg_write && reg_addr == ADDR_EP0_DATA) begin
				ep0_wptr_reg <= ep0_wptr_reg + 4'h1;
			end
			if (reg_write && reg_addr == ADDR_EP12_CTRL) begin
				shared_wptr_reg <= 4'h0;
			end else if (reg_write && reg_addr == ADDR_SHARED_DATA) begin
				shared_wptr_reg <= shared_wptr_reg + 4'h1;
			end
		end
	end

	// bus activity pin synchroniser
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			act1_reg <= 1'b0;
			act2_reg <= 1'b0;
			act3_reg <= 1'b0;
			activity_reg <= 1'b0;
		end else begin
			act1_reg <= bus_activity_pin;
			act2_reg <= act1_reg;
			act3_reg <= act2_reg;
			if (act2_reg == act3_reg) begin
				activity_reg <= act3_reg;
			end
		end
	end

	// sticky done flags, write one to clear, set wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx0_done_reg <= 1'b0;
			rx0_done_reg <= 1'b0;
			tx1_done_reg <= 1'b0;
			resume_flag_reg <= 1'b0;
		end else begin
			if (tx_ack_event && !cur_shared_reg) begin
				tx0_done_reg <= 1'b1; // see [RL17]
			end else if (reg_write && reg_addr == ADDR_FLAGS && reg_wdata[FLAG_TX0_BIT]) begin
				tx0_done_reg <= 1'b0;
			end
			if (rx_ok_event) begin
				rx0_done_reg <= 1'b1; // see [RL18]
			end else if (reg_write && reg_addr == ADDR_FLAGS && reg_wdata[FLAG_RX0_BIT]) begin
				rx0_done_reg <= 1'b0;
			end
			if (tx_ack_event && cur_shared_reg) begin
				tx1_done_reg <= 1'b1;
			end else if (reg_write && reg_addr == ADDR_FLAGS && reg_wdata[FLAG_TX1_BIT]) begin
				tx1_done_reg <= 1'b0;
			end
			if (activity_reg && suspended && !ep12_ctrl_reg[WAKEUP_BIT]) begin
				resume_flag_reg <= 1'b1; // see [RL16]
			end else if (reg_write && reg_addr == ADDR_FLAGS
				&& reg_wdata[FLAG_RESUME_BIT]) begin
				resume_flag_reg <= 1'b0;
			end
		end
	end

	// read data, valid only the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (reset || !reg_read) begin
			rdata_reg <= 8'h00;
		end else begin
			case (reg_addr)
				ADDR_EP0_CTRL: rdata_reg <= ep0_ctrl_reg;
				ADDR_EP12_CTRL: rdata_reg <= ep12_ctrl_reg;
				ADDR_EP_CTRL: rdata_reg <= {3'h0, ep_ctrl_reg};
				ADDR_FLAGS: rdata_reg <= {3'h0, tx0_done_reg, rx0_done_reg, tx1_done_reg,
					1'b0, resume_flag_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_reg;
	assign resp_valid = resp_valid_reg;
	assign resp_kind = resp_kind_reg;
	assign resp_data1 = resp_data1_reg;
	assign tx_byte_valid = tx_valid_reg;
	assign tx_byte_data = buf_bus.rdata;
	assign tx_byte_last = tx_last_reg;
	assign resume_k_drive = ep12_ctrl_reg[WAKEUP_BIT]; // see [RL14]

endmodule : usb_endpoint_tx_control

`default_nettype wire

/* verilog/usb_ep_pkg.sv */
// constants, types and helpers shared by the endpoint control block
// assumes a single 25 MHz ref_clk domain with synchronous reset
// How it works
// [RL1] endpoint 0 toggle picks DATA0 or DATA1
// [RL2] endpoint 0 stall answers IN/OUT with STALL
// [RL3] SETUP token clears endpoint 0 stall
// [RL4] endpoint 0 IN NAKed if disabled or done
// [RL5] endpoint 0 OUT NAKed if disabled or done; code ACKs it anyway while the auto-out bit is set
// [RL6] software manages endpoint 0 transmit enable
// [RL7] software manages endpoint 0 receive enable
// [RL8] both control registers hold 4-bit counts
// [RL9] shared toggle picks DATA0 or DATA1
// [RL10] shared select: 0 endpoint 1, 1 endpoint 2
// [RL11] endpoint 2 IN with select 0 gets NAK
// [RL12] shared IN NAKed if disabled or done
// [RL13] software manages shared transmit enable
// [RL14] wake-up bit drives resume K state
// [RL15] software holds wake-up bit 10 to 15 ms
// [RL16] forced resume never sets resume flag
// [RL17] endpoint 0 transmit done set on ACK
// [RL18] endpoint 0 receive done set after ACK; code does not set it for OUTs ACKed under the auto-out bit
// [RL19] endpoint 1/2 enable and stall, reset cleared
// [RL20] accepted IN sends exactly the byte count
`default_nettype none

package usb_ep_pkg;

	localparam logic [7:0] ADDR_SHARED_DATA = 8'he6;
	localparam logic [7:0] ADDR_EP0_DATA = 8'he7;
	localparam logic [7:0] ADDR_EP0_CTRL = 8'hea;
	localparam logic [7:0] ADDR_EP12_CTRL = 8'heb;
	localparam logic [7:0] ADDR_EP_CTRL = 8'hec;
	localparam logic [7:0] ADDR_FLAGS = 8'hf0;

	localparam int EP0_TOGGLE_BIT = 7;
	localparam int EP0_STALL_BIT = 6;
	localparam int EP0_TXEN_BIT = 5;
	localparam int EP0_RXEN_BIT = 4;
	localparam int SH_TOGGLE_BIT = 7;
	localparam int SH_SELECT_BIT = 6;
	localparam int SH_TXEN_BIT = 5;
	localparam int WAKEUP_BIT = 4;
	localparam int AUTO_OUT_BIT = 4;
	localparam int EP2_EN_BIT = 3;
	localparam int EP1_EN_BIT = 2;
	localparam int EP2_STALL_BIT = 1;
	localparam int EP1_STALL_BIT = 0;
	localparam int FLAG_TX0_BIT = 4;
	localparam int FLAG_RX0_BIT = 3;
	localparam int FLAG_TX1_BIT = 2;
	localparam int FLAG_RESUME_BIT = 0;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [4:0] EP_CTRL_RESET = 5'h00;
	localparam logic [7:0] EP_CTRL_MASK = 8'h1f;
	localparam logic [7:0] FLAGS_MASK = 8'h1d;

	typedef enum logic [1:0] {TOKEN_OUT, TOKEN_IN, TOKEN_SETUP, TOKEN_OTHER} token_e;
	typedef enum logic [1:0] {RESP_ACK, RESP_NAK, RESP_STALL, RESP_DATA} resp_e;

	// an endpoint may move data only when enabled and its done flag is clear
	function automatic logic path_open(input logic enable, input logic done);
		return enable & ~done;
	endfunction : path_open

endpackage : usb_ep_pkg

`default_nettype wire

/* verilog/usb_tx_buffer.sv */
// two 16-byte transmit stores, endpoint 0 and the shared endpoint 1/2 path
// assumes read address held stable one cycle before data is used
`default_nettype none

module usb_tx_buffer (
	input wire logic ref_clk,
	input wire logic reset,
	tx_buf_if.mem buf_port
);
	logic [7:0] store_reg [0:31];
	logic [7:0] rdata_reg;

	always_ff @(posedge ref_clk) begin
		if (buf_port.we) begin
			store_reg[{buf_port.wsel, buf_port.waddr}] <= buf_port.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= store_reg[{buf_port.rsel, buf_port.raddr}];
		end
	end

	assign buf_port.rdata = rdata_reg;

endmodule : usb_tx_buffer

`default_nettype wire
